// File: dv/rtc_core_checker.sv
// Checker for the clock core: pin modes, snapshot, identifier, alarm flags and write cycle.
// Assumes it is bound to rtc_core with one clock and a synchronous reset.
`timescale 1ns/1ps
module rtc_core_checker #(
    parameter int          NVW_CYC = 16,
    parameter logic [63:0] UID     = 64'h0
) (
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    input wire logic        crystal_amp_input_i,
    input wire logic        crystal_amp_output_o,
    input wire logic        set_time_i,
    input wire logic [55:0] set_value_i,
    input wire logic        snapshot_i,
    input wire logic [55:0] time_snapshot_o,
    input wire logic        clock_running_o,
    input wire logic [1:0]  alarm_irq_en_i,
    input wire logic        status_read_done_i,
    input wire logic        alarm_a_match_flag_o,
    input wire logic        alarm_b_match_flag_o,
    input wire logic [2:0]  fout_sel_i,
    input wire logic        alarm_or_clock_out_pin_o,
    input wire logic        alarm_or_clock_out_pin_oe_o,
    input wire logic [63:0] unique_id_o,
    input wire logic        nv_write_stop_i,
    input wire logic        nv_write_busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    logic [31:0] busy_cnt_q;
    always_ff @(posedge core_clk_i) begin
        if (srst_i || !nv_write_busy_o) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h1;
        end
    end
    sequence set_then_snap;
        set_time_i ##1 (snapshot_i && !set_time_i);
    endsequence
    sequence nv_accept;
        nv_write_stop_i && !nv_write_busy_o;
    endsequence
    set_snap_a: assert property (set_then_snap |=> time_snapshot_o == $past(set_value_i, 2))
        else $error("snapshot after set differs from set value");
    run_set_a: assert property (set_time_i |=> clock_running_o)
        else $error("clock not running after set");
    snap_hold_a: assert property (!$past(srst_i) && !$past(snapshot_i) |-> $stable(time_snapshot_o))
        else $error("holding latch changed without snapshot");
    nv_start_a: assert property (nv_accept |=> nv_write_busy_o)
        else $error("write cycle did not start");
    nv_len_a: assert property ($fell(nv_write_busy_o) && !$past(srst_i) |-> busy_cnt_q == NVW_CYC)
        else $error("write cycle length wrong");
    pin_low_a: assert property (!alarm_or_clock_out_pin_o)
        else $error("open-drain data not low");
    irq_pin_a: assert property (!$past(srst_i) && $past(fout_sel_i) == 3'h0 |->
        alarm_or_clock_out_pin_oe_o == $past(|({alarm_b_match_flag_o, alarm_a_match_flag_o} & alarm_irq_en_i)))
        else $error("interrupt pin does not follow enabled flags");
    off_pin_a: assert property (!$past(srst_i) && $past(fout_sel_i) > 3'h3 |-> !alarm_or_clock_out_pin_oe_o)
        else $error("inactive pin is driven");
    fast_pin_a: assert property (!$past(srst_i) && $past(fout_sel_i) == 3'h3 |->
        alarm_or_clock_out_pin_oe_o == $past(crystal_amp_output_o))
        else $error("crystal-rate output wrong");
    amp_inv_a: assert property (!$past(srst_i) |-> crystal_amp_output_o == !$past(crystal_amp_input_i))
        else $error("amplifier output not inverse of input");
    uid_fixed_a: assert property (!$past(srst_i) |-> unique_id_o == UID)
        else $error("identifier changed");
    flag_clear_a: assert property (($fell(alarm_a_match_flag_o) || $fell(alarm_b_match_flag_o))
        && !$past(srst_i) |-> $past(status_read_done_i))
        else $error("alarm flag cleared without status read");
endmodule
bind rtc_core rtc_core_checker #(.NVW_CYC(NVW_CYC), .UID(UID)) u_chk (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .crystal_amp_input_i(crystal_amp_input_i), .crystal_amp_output_o(crystal_amp_output_o),
    .set_time_i(set_time_i), .set_value_i(set_value_i), .snapshot_i(snapshot_i),
    .time_snapshot_o(time_snapshot_o), .clock_running_o(clock_running_o), .alarm_irq_en_i(alarm_irq_en_i),
    .status_read_done_i(status_read_done_i), .alarm_a_match_flag_o(alarm_a_match_flag_o),
    .alarm_b_match_flag_o(alarm_b_match_flag_o), .fout_sel_i(fout_sel_i),
    .alarm_or_clock_out_pin_o(alarm_or_clock_out_pin_o), .alarm_or_clock_out_pin_oe_o(alarm_or_clock_out_pin_oe_o),
    .unique_id_o(unique_id_o), .nv_write_stop_i(nv_write_stop_i), .nv_write_busy_o(nv_write_busy_o));

// File: dv/rtc_xtal_host_model.sv
// Far-side model: the crystal's square wave and the pull-up resistor on the open-drain pin.
// Assumes the crystal is sped up to one rise every two core cycles so that one second fits the run.
`timescale 1ns/1ps
module rtc_xtal_host_model (
    input  wire logic core_clk_i,
    input  wire logic run_i,
    input  wire logic pin_i,
    input  wire logic pin_oe_i,
    output var  logic xtal_o,
    output wire logic pin_level_o
);
    initial xtal_o = 1'b0;
    always @(posedge core_clk_i) begin
        if (run_i) begin
            xtal_o <= #2 ~xtal_o;
        end
    end
    // The pull-up holds the wire high whenever the core does not drive it.
    assign pin_level_o = pin_oe_i ? pin_i : 1'b1;
endmodule

// File: dv/test_rtc_core.sv
// Self-checking bench for the clock core: reset, pin modes, write cycle, set, calendar tick and alarms.
// Assumes the crystal model gives one crystal rise every two core cycles.
`timescale 1ns/1ps
module test_rtc_core;
    localparam int          NVW   = 16;
    localparam logic [63:0] UID_T = 64'h0123_4567_89ab_cdef; // Arbitrary identifier value.
    logic        clk       = 1'b0;
    logic        srst      = 1'b1;
    logic        run       = 1'b0;
    logic        set_time  = 1'b0;
    logic [55:0] set_value = 56'h0;
    logic        snap      = 1'b0;
    logic [1:0]  irq_en    = 2'h0;
    logic [6:0]  en_b      = 7'h00;
    logic        rd_start  = 1'b0;
    logic        rd_done   = 1'b0;
    logic [2:0]  fsel      = 3'h0;
    logic        nv_stop   = 1'b0;
    logic        xtal;
    wire         amp_out, running, fl_a, fl_b, pin, pin_oe, busy, pin_level;
    wire  [55:0] snap_val;
    wire  [63:0] uid;
    int          bad_count = 0;
    int          cmp_count = 0;
    always #12.5 clk = ~clk;
    rtc_core #(.NVW_CYC(NVW), .UID(UID_T)) u_dut (.core_clk_i(clk), .srst_i(srst), .crystal_amp_input_i(xtal),
        .crystal_amp_output_o(amp_out), .set_time_i(set_time), .set_value_i(set_value), .snapshot_i(snap),
        .time_snapshot_o(snap_val), .clock_running_o(running), .alarm_a_value_i(56'h00_00_00_29_00_00_00),
        .alarm_a_enable_i(7'h08), .alarm_b_value_i(56'h0), .alarm_b_enable_i(en_b), .alarm_pulse_mode_i(2'h2),
        .alarm_rearm_i(2'h0), .alarm_irq_en_i(irq_en), .status_read_start_i(rd_start),
        .status_read_done_i(rd_done), .alarm_a_match_flag_o(fl_a), .alarm_b_match_flag_o(fl_b), .fout_sel_i(fsel),
        .alarm_or_clock_out_pin_o(pin), .alarm_or_clock_out_pin_oe_o(pin_oe), .unique_id_o(uid),
        .nv_write_stop_i(nv_stop), .nv_write_busy_o(busy));
    rtc_xtal_host_model u_far (.core_clk_i(clk), .run_i(run), .pin_i(pin), .pin_oe_i(pin_oe), .xtal_o(xtal),
        .pin_level_o(pin_level));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic take_snapshot();
        snap = 1'b1;
        step(1);
        snap = 1'b0;
    endtask
    task automatic t_reset();
        check("flags", {fl_b, fl_a}, 2'h0);
        check("pin enable", pin_oe, 1'b0);
        check("busy", busy, 1'b0);
        check("identifier", uid, UID_T);
        take_snapshot();
        check("reset time", snap_val, 56'h00_00_01_01_00_00_00);
        $display("test reset done");
    endtask
    task automatic t_freq();
        int n;
        logic prev;
        for (int sel = 1; sel < 8; sel++) begin
            fsel = sel[2:0];
            step(4);
            n = 0;
            prev = pin_oe;
            repeat (64) begin
                step(1);
                if (pin_oe !== prev) n++;
                prev = pin_oe;
            end
            check("pin toggles", n, sel == 2 ? 8 : sel == 3 ? 64 : 0);
            if (sel > 3) check("inactive pin", pin_level, 1'b1);
        end
        fsel = 3'h0;
        $display("test frequency output done");
    endtask
    task automatic t_nv();
        int n = 1;
        nv_stop = 1'b1;
        step(1);
        nv_stop = 1'b0;
        check("busy start", busy, 1'b1);
        while (n < 100) begin
            nv_stop = (n == 5);
            step(1);
            if (busy !== 1'b1) break;
            n++;
        end
        nv_stop = 1'b0;
        check("busy length", n, NVW);
        $display("test write cycle done");
    endtask
    task automatic t_set();
        irq_en = 2'h1;
        en_b = 7'h01;
        set_value = 56'h03_24_02_28_23_59_59;
        set_time = 1'b1;
        step(1);
        set_time = 1'b0;
        check("running", running, 1'b1);
        take_snapshot();
        check("set time", snap_val, set_value);
        $display("test set done");
    endtask
    task automatic t_tick();
        int n = 0;
        rd_start = 1'b1;
        step(1);
        rd_start = 1'b0;
        while (fl_a !== 1'b1 && n < 70000) begin
            step(1);
            n++;
        end
        if (n == 70000) begin
            bad_count++;
            $display("wrong value alarm wait: expected flag, seen timeout");
        end
        step(2);
        check("flags after tick", {fl_b, fl_a}, 2'h3);
        check("pin level", pin_level, 1'b0);
        take_snapshot();
        check("leap day", snap_val, 56'h04_24_02_29_00_00_00);
        irq_en = 2'h0;
        step(2);
        check("masked pin", pin_oe, 1'b0);
        rd_done = 1'b1;
        step(1);
        rd_done = 1'b0;
        check("flags set during read", {fl_b, fl_a}, 2'h3);
        $display("test tick done");
    endtask
    task automatic t_read();
        rd_start = 1'b1;
        step(1);
        rd_start = 1'b0;
        step(3);
        rd_done = 1'b1;
        step(1);
        rd_done = 1'b0;
        step(1);
        check("flags after read", {fl_b, fl_a}, 2'h0);
        $display("test status read done");
    endtask
    initial begin
        step(4);
        srst = 1'b0;
        run = 1'b1;
        step(1);
        t_reset();
        t_freq();
        t_nv();
        t_set();
        t_tick();
        t_read();
        finish_test();
    end
endmodule

// File: logic/rtc_core.v
// Real-time clock and calendar core with two alarms and a dual-function open-drain pin.
// Assumes a serial front end that turns serial-clock events into one-cycle strobes on core_clk_i.
`timescale 1ns/1ps
`include "rtc_defines.vh"

module rtc_core #(
    parameter        NVW_CYC = `RTC_NVW_MAX_CYC,
    parameter [63:0] UID     = `RTC_UID_RST
) (
    input  wire        core_clk_i,
    input  wire        srst_i,
    input  wire        crystal_amp_input_i,
    output wire        crystal_amp_output_o,
    input  wire        set_time_i,
    input  wire [55:0] set_value_i,
    input  wire        snapshot_i,
    output wire [55:0] time_snapshot_o,
    output wire        clock_running_o,
    input  wire [55:0] alarm_a_value_i,
    input  wire [6:0]  alarm_a_enable_i,
    input  wire [55:0] alarm_b_value_i,
    input  wire [6:0]  alarm_b_enable_i,
    input  wire [1:0]  alarm_pulse_mode_i,
    input  wire [1:0]  alarm_rearm_i,
    input  wire [1:0]  alarm_irq_en_i,
    input  wire        status_read_start_i,
    input  wire        status_read_done_i,
    output wire        alarm_a_match_flag_o,
    output wire        alarm_b_match_flag_o,
    input  wire [2:0]  fout_sel_i,
    output wire        alarm_or_clock_out_pin_o,
    output wire        alarm_or_clock_out_pin_oe_o,
    output wire [63:0] unique_id_o,
    input  wire        nv_write_stop_i,
    output wire        nv_write_busy_o
);

    localparam [31:0] NVW_LAST = NVW_CYC - 1;

    // Adds one to a two-digit BCD value.
    function [7:0] bcd_inc;
        input [7:0] v;
        begin
            if (v[3:0] == 4'h9) begin
                bcd_inc = {v[7:4] + 4'h1, 4'h0};
            end else begin
                bcd_inc = {v[7:4], v[3:0] + 4'h1};
            end
        end
    endfunction

    // BCD year divisible by four: even tens with units 0, 4, 8, or odd tens with units 2, 6.
    function leap_year;
        input [7:0] y;
        begin
            if (y[4] == 1'b0) begin
                leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
            end else begin
                leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
            end
        end
    endfunction

    // Last date of a month in BCD.
    function [7:0] month_days;
        input [7:0] m;
        input [7:0] y;
        begin
            case (m)
                8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
                `RTC_FEB:                   month_days = leap_year(y) ? 8'h29 : 8'h28;
                default:                    month_days = 8'h31;
            endcase
        end
    endfunction

    // True when every enabled field equals the running time and at least one field is enabled.
    function alarm_hit;
        input [55:0] val;
        input [6:0]  en;
        input [55:0] now;
        integer      k;
        reg          ok;
        begin
            ok = |en;
            for (k = 0; k < `RTC_NFIELD; k = k + 1) begin
                if (en[k] && (val[k*8 +: 8] != now[k*8 +: 8])) begin
                    ok = 1'b0;
                end
            end
            alarm_hit = ok;
        end
    endfunction

    reg                   xtal_q;
    reg                   xamp_q;
    reg [`RTC_DIV_W-1:0]  div_q;
    reg                   tick_q;
    reg                   run_q;
    reg [7:0]             sec_q;
    reg [7:0]             min_q;
    reg [7:0]             hour_q;
    reg [7:0]             date_q;
    reg [7:0]             mon_q;
    reg [7:0]             year_q;
    reg [7:0]             wday_q;
    reg [55:0]            snap_q;
    reg [1:0]             armed_q;
    reg [1:0]             flag_q;
    reg [1:0]             pend_q;
    reg                   pin_q;
    reg                   pin_oe_q;
    reg [63:0]            uid_q;
    reg [31:0]            nvw_cnt_q;
    reg                   nvw_busy_q;

    wire        xtal_rise = crystal_amp_input_i & ~xtal_q;
    wire        sec_tick  = run_q & xtal_rise & (div_q == `RTC_DIV_LAST);
    wire [55:0] now_vec   = {wday_q, year_q, mon_q, date_q, hour_q, min_q, sec_q};
    wire [1:0]  hit;

    // Crystal sampling and the inverting amplifier that keeps the resonator going.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            xtal_q <= 1'b0;
            xamp_q <= 1'b1;
        end else begin
            xtal_q <= crystal_amp_input_i;
            xamp_q <= ~crystal_amp_input_i;
        end
    end

    // Divide by 32768 to form the second tick.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            div_q  <= {`RTC_DIV_W{1'b0}};
            tick_q <= 1'b0;
        end else begin
            if (set_time_i) begin
                div_q <= {`RTC_DIV_W{1'b0}};
            end else if (xtal_rise) begin
                div_q <= div_q + 1'b1;
            end
            tick_q <= sec_tick;
        end
    end

    // Time and calendar counters; the clock stays stopped until it has been set once.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            run_q  <= 1'b0;
            sec_q  <= `RTC_SEC_RST;
            min_q  <= `RTC_MIN_RST;
            hour_q <= `RTC_HOUR_RST;
            date_q <= `RTC_DATE_RST;
            mon_q  <= `RTC_MON_RST;
            year_q <= `RTC_YEAR_RST;
            wday_q <= `RTC_WDAY_RST;
        end else if (set_time_i) begin
            run_q  <= 1'b1;
            sec_q  <= set_value_i[`RTC_SEC_LSB  +: 8];
            min_q  <= set_value_i[`RTC_MIN_LSB  +: 8];
            hour_q <= set_value_i[`RTC_HOUR_LSB +: 8];
            date_q <= set_value_i[`RTC_DATE_LSB +: 8];
            mon_q  <= set_value_i[`RTC_MON_LSB  +: 8];
            year_q <= set_value_i[`RTC_YEAR_LSB +: 8];
            wday_q <= set_value_i[`RTC_WDAY_LSB +: 8];
        end else if (sec_tick) begin
            if (sec_q != `RTC_SEC_MAX) begin
                sec_q <= bcd_inc(sec_q);
            end else begin
                sec_q <= 8'h00;
                if (min_q != `RTC_MIN_MAX) begin
                    min_q <= bcd_inc(min_q);
                end else begin
                    min_q <= 8'h00;
                    if (hour_q != `RTC_HOUR_MAX) begin
                        hour_q <= bcd_inc(hour_q);
                    end else begin
                        hour_q <= 8'h00;
                        wday_q <= (wday_q == `RTC_WDAY_MAX) ? 8'h00 : bcd_inc(wday_q);
                        if (date_q != month_days(mon_q, year_q)) begin
                            date_q <= bcd_inc(date_q);
                        end else begin
                            date_q <= 8'h01;
                            if (mon_q != `RTC_MON_MAX) begin
                                mon_q <= bcd_inc(mon_q);
                            end else begin
                                mon_q  <= 8'h01;
                                year_q <= (year_q == `RTC_YEAR_MAX) ? 8'h00 : bcd_inc(year_q);
                            end
                        end
                    end
                end
            end
        end
    end

    // The holding latch keeps a read stable while the counters run on.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            snap_q <= 56'h0;
        end else if (snapshot_i) begin
            snap_q <= now_vec;
        end
    end

    // Alarm comparison one cycle after the counters advance.
    generate
        genvar g;
        for (g = 0; g < 2; g = g + 1) begin : g_alarm
            wire [55:0] val = (g == 0) ? alarm_a_value_i : alarm_b_value_i;
            wire [6:0]  en  = (g == 0) ? alarm_a_enable_i : alarm_b_enable_i;
            assign hit[g] = tick_q & armed_q[g] & alarm_hit(val, en, now_vec);

            always @(posedge core_clk_i) begin
                if (srst_i) begin
                    armed_q[g] <= 1'b1;
                    flag_q[g]  <= 1'b0;
                    pend_q[g]  <= 1'b0;
                end else begin
                    if (alarm_rearm_i[g]) begin
                        armed_q[g] <= 1'b1;
                    end else if (hit[g] && !alarm_pulse_mode_i[g]) begin
                        armed_q[g] <= 1'b0;
                    end
                    // A finished read drops its pending set, so a later done strobe clears nothing.
                    if (status_read_start_i) begin
                        pend_q[g] <= flag_q[g];
                    end else if (status_read_done_i) begin
                        pend_q[g] <= 1'b0;
                    end
                    // A match in the clearing cycle keeps the flag set.
                    flag_q[g] <= hit[g] | (flag_q[g] & ~(status_read_done_i & pend_q[g]));
                end
            end
        end
    endgenerate

    // Dual-function pin: open drain, so enable high means the pin is pulled low.
    reg fclk;
    reg drive_low;
    always @* begin
        fclk      = 1'b1;
        drive_low = 1'b0;
        case (fout_sel_i)
            `RTC_FSEL_IRQ: drive_low = |(flag_q & alarm_irq_en_i);
            `RTC_FSEL_1HZ: fclk = div_q[`RTC_F1HZ_BIT];
            `RTC_FSEL_4K:  fclk = div_q[`RTC_F4K_BIT];
            `RTC_FSEL_32K: fclk = xtal_q;
            default:       fclk = 1'b1;
        endcase
        if (fout_sel_i != `RTC_FSEL_IRQ) begin
            drive_low = ~fclk;
        end
    end

    always @(posedge core_clk_i) begin
        if (srst_i) begin
            pin_q    <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            pin_q    <= 1'b0;
            pin_oe_q <= drive_low;
        end
    end

    // Identifier loaded from RTC_UID_RST in reset and from UID after it; nothing can write it.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            uid_q <= `RTC_UID_RST;
        end else begin
            uid_q <= UID;
        end
    end

    // Self-timed non-volatile write started by the stop of a valid write.
    always @(posedge core_clk_i) begin
        if (srst_i) begin
            nvw_cnt_q  <= 32'h0;
            nvw_busy_q <= 1'b0;
        end else if (nv_write_stop_i && !nvw_busy_q) begin
            nvw_cnt_q  <= 32'h0;
            nvw_busy_q <= 1'b1;
        end else if (nvw_busy_q) begin
            nvw_cnt_q <= nvw_cnt_q + 32'h1;
            if (nvw_cnt_q == NVW_LAST) begin
                nvw_busy_q <= 1'b0;
            end
        end
    end

    // Serial-clock events arrive as strobes; nv_write_stop_i is ignored while a write cycle is busy.
    assign crystal_amp_output_o        = xamp_q;
    assign time_snapshot_o             = snap_q;
    assign clock_running_o             = run_q;
    assign alarm_a_match_flag_o        = flag_q[0];
    assign alarm_b_match_flag_o        = flag_q[1];
    assign alarm_or_clock_out_pin_o    = pin_q;
    assign alarm_or_clock_out_pin_oe_o = pin_oe_q;
    assign unique_id_o                 = uid_q;
    assign nv_write_busy_o             = nvw_busy_q;

endmodule

// File: logic/rtc_defines.vh
// Constants of the real-time clock core: divider, field layout, reset values and timing.
// Assumes the including module runs on a 40 MHz core clock with synchronous inputs.
`ifndef RTC_DEFINES_VH
`define RTC_DEFINES_VH

`define RTC_XTAL_HZ        32768
`define RTC_CORE_HZ        40000000
`define RTC_DIV_W          15
`define RTC_DIV_LAST       15'h7fff
`define RTC_F4K_BIT        2
`define RTC_F1HZ_BIT       14

`define RTC_NVW_TYP_MS     12
`define RTC_NVW_MAX_MS     20
`define RTC_NVW_MAX_CYC    ((`RTC_NVW_MAX_MS * `RTC_CORE_HZ) / 1000)

`define RTC_FSEL_IRQ       3'h0
`define RTC_FSEL_1HZ       3'h1
`define RTC_FSEL_4K        3'h2
`define RTC_FSEL_32K       3'h3

`define RTC_SEC_LSB        0
`define RTC_MIN_LSB        8
`define RTC_HOUR_LSB       16
`define RTC_DATE_LSB       24
`define RTC_MON_LSB        32
`define RTC_YEAR_LSB       40
`define RTC_WDAY_LSB       48
`define RTC_NFIELD         7

`define RTC_SEC_RST        8'h00
`define RTC_MIN_RST        8'h00
`define RTC_HOUR_RST       8'h00
`define RTC_DATE_RST       8'h01
`define RTC_MON_RST        8'h01
`define RTC_YEAR_RST       8'h00
`define RTC_WDAY_RST       8'h00

`define RTC_SEC_MAX        8'h59
`define RTC_MIN_MAX        8'h59
`define RTC_HOUR_MAX       8'h23
`define RTC_MON_MAX        8'h12
`define RTC_YEAR_MAX       8'h99
`define RTC_WDAY_MAX       8'h06
`define RTC_FEB            8'h02

`define RTC_UID_RST        64'h5a5a_3c3c_0f0f_1234

`endif
